// ---- rtl/rtc_pkg.sv ----
package rtc_pkg;
    // Serial addresses
    localparam logic [7:0] ADDR_GEN_RESET = 8'h10;
    localparam logic [7:0] ADDR_GCR = 8'h11;
    localparam logic [7:0] ADDR_RXC = 8'h12;
    localparam logic [7:0] ADDR_RXM = 8'h13;
    localparam logic [7:0] ADDR_TXC = 8'h14;
    localparam logic [7:0] ADDR_GCR_RB = 8'hE1;
    localparam logic [7:0] ADDR_RXC_RB = 8'hE2;
    localparam logic [7:0] ADDR_RXM_RB = 8'hE3;
    localparam logic [7:0] ADDR_TXC_RB = 8'hE4;
    // Reset value of every write register
    localparam logic [7:0] REG_RESET = 8'h00;
    // General control fields
    localparam int GCR_BIAS = 7;
    localparam int GCR_HIGH_IF = 6;
    localparam int GCR_CHAN_SEL = 5;
    localparam int GCR_OUT_MODE = 4;
    localparam int GCR_NEGRES_HI = 3;
    localparam int GCR_NEGRES_LO = 2;
    localparam int GCR_OSC_BUF = 1;
    localparam int GCR_OSC_AMP = 0;
    // Receive control fields
    localparam int RXC_MIX1 = 7;
    localparam int RXC_IF_CHAIN = 6;
    localparam int RXC_BB_AMP = 5;
    localparam int RXC_LEVEL = 4;
    localparam int RXC_LNA = 3;
    localparam int RXC_DIV_HI = 2;
    localparam int RXC_DIV_LO = 1;
    localparam int RXC_BIAS_VOLTAGE_OUT_ON = 0;
    // Receive mode fields
    localparam int RXM_IF_IN = 7;
    localparam int RXM_MIX_OUT = 6;
    localparam int RXM_WIDE_BW = 5;
    localparam int RXM_CAL = 4;
    localparam int RXM_GAIN_HI = 3;
    // Transmit control fields
    localparam int TXC_UPCONV = 6;
    localparam int TXC_IQ_MOD = 4;
    localparam int TXC_LO_HIGH = 1;
    localparam int TXC_IF_PIN = 0;
    // Receive LO divider codes
    localparam logic [1:0] DIV_CODE_BY2 = 2'h0;
    localparam logic [1:0] DIV_CODE_BY1 = 2'h1;
    localparam logic [1:0] DIV_CODE_BY4 = 2'h2;
    // Gain step and largest legal gain code
    localparam logic [5:0] GAIN_STEP_DB = 6'h06;
    localparam logic [3:0] GAIN_CODE_MAX = 4'h8;
    localparam logic [5:0] GAIN_ATTEN_MAX = 6'h30;
    // Serial bit counter wrap
    localparam logic [2:0] BIT_LAST = 3'h7;
endpackage

// ---- rtl/rtc_regs.sv ----
`timescale 1ns/1ps
module rtc_regs (
    // Clock, reset, enable
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic clk_en,
    // Serial pins and reset pin
    input wire logic sclk,
    input wire logic csn_n,
    input wire logic cdata,
    input wire logic reset_pin_n,
    output logic rdata,
    // General section controls
    output logic bias_on,
    output logic high_if_select,
    output logic osc_buffer_on,
    output logic osc_amplifier_on,
    output logic osc_bypass,
    output logic [1:0] osc_negres_setting,
    // Receive channel controls
    output logic rx_if_mode,
    output logic rx_i_out_en,
    output logic rx_q_out_en,
    output logic rx_i_amp_on,
    output logic rx_q_amp_on,
    // Receive chain controls
    output logic mixer1_on,
    output logic if_chain_on,
    output logic level_indicator_on,
    output logic lna_control_pin,
    output logic [2:0] rx_lo_div_sel,
    output logic bias_voltage_out_on,
    output logic if_input_select,
    output logic mixer_output_b_sel,
    output logic iq_bw_wide,
    output logic [5:0] gain_atten_db,
    // Transmit controls
    output logic upconverter_on,
    output logic iq_mod_on,
    output logic tx_lo_high_band,
    output logic tx_if_to_pin
);

    // Serial engine states
    typedef enum logic [3:0] {
        RTC_ADDR = 4'h1,
        RTC_WDATA = 4'h2,
        RTC_RDATA = 4'h4,
        RTC_SKIP = 4'h8
    } rtc_state_t;

    // Synchroniser stages for the pins
    logic sclk_s1, sclk_s2, sclk_d;
    logic csn_s1, csn_s2;
    logic cdata_s1, cdata_s2;
    logic rpin_s1, rpin_s2;
    // Serial engine state
    rtc_state_t state_reg;
    logic [2:0] bit_cnt_reg;
    logic [6:0] shift_reg;
    logic [7:0] addr_reg;
    logic [7:0] out_sh_reg;
    logic rdata_reg;
    // Write and reset strobes to the register file
    logic wr_stb_reg;
    logic [7:0] wr_data_reg;
    logic gen_rst_reg;
    // Register file
    logic [7:0] gcr_reg, rxc_reg, rxm_reg, txc_reg;
    // Decode helpers
    logic sclk_rise, sclk_fall, pin_clear;
    logic [7:0] byte_in, mirror_byte;

    // Readback decode; unmapped reads give zero
    function automatic logic [7:0] read_mirror(input logic [7:0] a, input logic [7:0] g,
            input logic [7:0] rc, input logic [7:0] rm, input logic [7:0] tc);
        unique case (a)
            rtc_pkg::ADDR_GCR_RB: read_mirror = g;
            rtc_pkg::ADDR_RXC_RB: read_mirror = rc;
            rtc_pkg::ADDR_RXM_RB: read_mirror = rm;
            rtc_pkg::ADDR_TXC_RB: read_mirror = tc;
            default: read_mirror = 8'h00;
        endcase
    endfunction

    // Write-only address check
    function automatic logic is_write_addr(input logic [7:0] a);
        is_write_addr = (a == rtc_pkg::ADDR_GCR) || (a == rtc_pkg::ADDR_RXC) ||
            (a == rtc_pkg::ADDR_RXM) || (a == rtc_pkg::ADDR_TXC);
    endfunction

    // Read-only address check
    function automatic logic is_read_addr(input logic [7:0] a);
        is_read_addr = (a == rtc_pkg::ADDR_GCR_RB) || (a == rtc_pkg::ADDR_RXC_RB) ||
            (a == rtc_pkg::ADDR_RXM_RB) || (a == rtc_pkg::ADDR_TXC_RB);
    endfunction

    // Gain code to attenuation; illegal codes clamp to the deepest step
    function automatic logic [5:0] gain_decode(input logic [3:0] c);
        logic [5:0] prod;
        prod = 6'(c) * rtc_pkg::GAIN_STEP_DB;
        gain_decode = (c > rtc_pkg::GAIN_CODE_MAX) ? rtc_pkg::GAIN_ATTEN_MAX : prod;
    endfunction

    assign sclk_rise = sclk_s2 & ~sclk_d;
    assign sclk_fall = ~sclk_s2 & sclk_d;
    assign pin_clear = ~rpin_s2;
    assign byte_in = {shift_reg, cdata_s2};
    assign mirror_byte = read_mirror(addr_reg, gcr_reg, rxc_reg, rxm_reg, txc_reg);

    // Pin synchronisers; second stage feeds all logic
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            sclk_s1 <= 1'b0;
            sclk_s2 <= 1'b0;
            sclk_d <= 1'b0;
            csn_s1 <= 1'b1;
            csn_s2 <= 1'b1;
            cdata_s1 <= 1'b0;
            cdata_s2 <= 1'b0;
            rpin_s1 <= 1'b1;
            rpin_s2 <= 1'b1;
        end else if (clk_en) begin
            sclk_s1 <= sclk;
            sclk_s2 <= sclk_s1;
            sclk_d <= sclk_s2;
            csn_s1 <= csn_n;
            csn_s2 <= csn_s1;
            cdata_s1 <= cdata;
            cdata_s2 <= cdata_s1;
            rpin_s1 <= reset_pin_n;
            rpin_s2 <= rpin_s1;
        end
    end

    // Serial engine: address byte then data bytes
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            state_reg <= RTC_ADDR;
            bit_cnt_reg <= 3'h0;
            shift_reg <= 7'h00;
            addr_reg <= 8'h00;
            wr_stb_reg <= 1'b0;
            wr_data_reg <= 8'h00;
            gen_rst_reg <= 1'b0;
        end else if (clk_en) begin
            wr_stb_reg <= 1'b0;
            gen_rst_reg <= 1'b0;
            if (csn_s2 || pin_clear) begin
                // Deselect aborts any partial byte
                state_reg <= RTC_ADDR;
                bit_cnt_reg <= 3'h0;
            end else if (sclk_rise) begin
                shift_reg <= byte_in[6:0];
                bit_cnt_reg <= bit_cnt_reg + 3'h1;
                if (bit_cnt_reg == rtc_pkg::BIT_LAST) begin
                    unique case (state_reg)
                        RTC_ADDR: begin
                            addr_reg <= byte_in;
                            if (byte_in == rtc_pkg::ADDR_GEN_RESET) begin
                                gen_rst_reg <= 1'b1;
                                state_reg <= RTC_SKIP;
                            end else if (is_write_addr(byte_in)) begin
                                state_reg <= RTC_WDATA;
                            end else if (is_read_addr(byte_in)) begin
                                state_reg <= RTC_RDATA;
                            end else begin
                                state_reg <= RTC_SKIP;
                            end
                        end
                        RTC_WDATA: begin
                            // Every full data byte rewrites the register
                            wr_stb_reg <= 1'b1;
                            wr_data_reg <= byte_in;
                        end
                        RTC_RDATA, RTC_SKIP: state_reg <= state_reg; // Bits ignored here
                    endcase
                end
            end
        end
    end

    // Readback shifter; changes on falling edges so the host samples on rising
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            out_sh_reg <= 8'h00;
            rdata_reg <= 1'b0;
        end else if (clk_en) begin
            if (state_reg != RTC_RDATA || csn_s2) begin
                out_sh_reg <= 8'h00;
                rdata_reg <= 1'b0;
            end else if (sclk_fall) begin
                if (bit_cnt_reg == 3'h0) begin
                    rdata_reg <= mirror_byte[7];
                    out_sh_reg <= {mirror_byte[6:0], 1'b0};
                end else begin
                    rdata_reg <= out_sh_reg[7];
                    out_sh_reg <= {out_sh_reg[6:0], 1'b0};
                end
            end
        end
    end

    // Register file; clear wins since it stands for a full device reset
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            gcr_reg <= rtc_pkg::REG_RESET;
            rxc_reg <= rtc_pkg::REG_RESET;
            rxm_reg <= rtc_pkg::REG_RESET;
            txc_reg <= rtc_pkg::REG_RESET;
        end else if (clk_en) begin
            if (gen_rst_reg || pin_clear) begin
                gcr_reg <= rtc_pkg::REG_RESET;
                rxc_reg <= rtc_pkg::REG_RESET;
                rxm_reg <= rtc_pkg::REG_RESET;
                txc_reg <= rtc_pkg::REG_RESET;
            end else if (wr_stb_reg) begin
                unique case (addr_reg)
                    rtc_pkg::ADDR_GCR: gcr_reg <= wr_data_reg;
                    rtc_pkg::ADDR_RXC: rxc_reg <= wr_data_reg;
                    rtc_pkg::ADDR_RXM: rxm_reg <= wr_data_reg;
                    rtc_pkg::ADDR_TXC: txc_reg <= wr_data_reg;
                    default: gcr_reg <= gcr_reg;
                endcase
            end
        end
    end

    // Control outputs, one flop each from the register file
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            bias_on <= 1'b0;
            high_if_select <= 1'b0;
            osc_buffer_on <= 1'b0;
            osc_amplifier_on <= 1'b0;
            osc_bypass <= 1'b1;
            osc_negres_setting <= 2'h0;
            rx_if_mode <= 1'b0;
            rx_i_out_en <= 1'b0;
            rx_q_out_en <= 1'b0;
            rx_i_amp_on <= 1'b0;
            rx_q_amp_on <= 1'b0;
            mixer1_on <= 1'b0;
            if_chain_on <= 1'b0;
            level_indicator_on <= 1'b0;
            lna_control_pin <= 1'b0;
            rx_lo_div_sel <= 3'h2;
            bias_voltage_out_on <= 1'b0;
            if_input_select <= 1'b0;
            mixer_output_b_sel <= 1'b0;
            iq_bw_wide <= 1'b0;
            gain_atten_db <= 6'h00;
            upconverter_on <= 1'b0;
            iq_mod_on <= 1'b0;
            tx_lo_high_band <= 1'b0;
            tx_if_to_pin <= 1'b0;
        end else if (clk_en) begin
            bias_on <= gcr_reg[rtc_pkg::GCR_BIAS];
            osc_buffer_on <= gcr_reg[rtc_pkg::GCR_OSC_BUF];
            osc_amplifier_on <= gcr_reg[rtc_pkg::GCR_OSC_AMP];
            osc_bypass <= ~gcr_reg[rtc_pkg::GCR_OSC_AMP];
            // Passed through; host picks the band
            high_if_select <= gcr_reg[rtc_pkg::GCR_HIGH_IF];
            osc_negres_setting <= {gcr_reg[rtc_pkg::GCR_NEGRES_HI],
                gcr_reg[rtc_pkg::GCR_NEGRES_LO]};
            rx_if_mode <= gcr_reg[rtc_pkg::GCR_OUT_MODE];
            if (!gcr_reg[rtc_pkg::GCR_OUT_MODE]) begin
                // I/Q mode, select has no effect
                rx_i_out_en <= rxc_reg[rtc_pkg::RXC_IF_CHAIN];
                rx_q_out_en <= rxc_reg[rtc_pkg::RXC_IF_CHAIN];
                rx_i_amp_on <= rxc_reg[rtc_pkg::RXC_BB_AMP];
                rx_q_amp_on <= rxc_reg[rtc_pkg::RXC_BB_AMP];
            end else begin
                // IF mode, only the selected channel may power
                rx_i_out_en <= rxc_reg[rtc_pkg::RXC_IF_CHAIN] &
                    ~gcr_reg[rtc_pkg::GCR_CHAN_SEL];
                rx_q_out_en <= rxc_reg[rtc_pkg::RXC_IF_CHAIN] &
                    gcr_reg[rtc_pkg::GCR_CHAN_SEL];
                rx_i_amp_on <= rxc_reg[rtc_pkg::RXC_BB_AMP] &
                    ~gcr_reg[rtc_pkg::GCR_CHAN_SEL];
                rx_q_amp_on <= rxc_reg[rtc_pkg::RXC_BB_AMP] &
                    gcr_reg[rtc_pkg::GCR_CHAN_SEL];
            end
            mixer1_on <= rxc_reg[rtc_pkg::RXC_MIX1] & ~rxm_reg[rtc_pkg::RXM_CAL];
            if_chain_on <= rxc_reg[rtc_pkg::RXC_IF_CHAIN];
            level_indicator_on <= rxc_reg[rtc_pkg::RXC_LEVEL];
            bias_voltage_out_on <= rxc_reg[rtc_pkg::RXC_BIAS_VOLTAGE_OUT_ON];
            lna_control_pin <= rxc_reg[rtc_pkg::RXC_LNA] & ~rxm_reg[rtc_pkg::RXM_CAL];
            // One-hot {by4, by2, by1}; forbidden code leaves all off
            unique case ({rxc_reg[rtc_pkg::RXC_DIV_HI], rxc_reg[rtc_pkg::RXC_DIV_LO]})
                rtc_pkg::DIV_CODE_BY2: rx_lo_div_sel <= 3'h2;
                rtc_pkg::DIV_CODE_BY1: rx_lo_div_sel <= 3'h1;
                rtc_pkg::DIV_CODE_BY4: rx_lo_div_sel <= 3'h4;
                default: rx_lo_div_sel <= 3'h0;
            endcase
            if_input_select <= rxm_reg[rtc_pkg::RXM_IF_IN];
            mixer_output_b_sel <= rxm_reg[rtc_pkg::RXM_MIX_OUT];
            iq_bw_wide <= rxm_reg[rtc_pkg::RXM_WIDE_BW];
            gain_atten_db <= gain_decode(rxm_reg[rtc_pkg::RXM_GAIN_HI:0]);
            upconverter_on <= txc_reg[rtc_pkg::TXC_UPCONV];
            iq_mod_on <= txc_reg[rtc_pkg::TXC_IQ_MOD];
            tx_lo_high_band <= txc_reg[rtc_pkg::TXC_LO_HIGH];
            tx_if_to_pin <= txc_reg[rtc_pkg::TXC_IF_PIN];
        end
    end

    assign rdata = rdata_reg;
    // Checks on the logic above
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    a_gen_reset_clears: assert property (gen_rst_reg && clk_en |=>
        gcr_reg == 8'h00 && rxc_reg == 8'h00 && rxm_reg == 8'h00 && txc_reg == 8'h00)
        else $error("general reset left a register set");
    a_write_lands: assert property (wr_stb_reg && clk_en && !pin_clear && !gen_rst_reg &&
        addr_reg == rtc_pkg::ADDR_RXM |=> rxm_reg == $past(wr_data_reg))
        else $error("data byte not stored");
    a_lna_follows: assert property (clk_en |=> lna_control_pin ==
        $past(rxc_reg[rtc_pkg::RXC_LNA] & ~rxm_reg[rtc_pkg::RXM_CAL]))
        else $error("lna pin wrong");
    a_if_one_chan: assert property (rx_if_mode |-> !(rx_i_amp_on && rx_q_amp_on) &&
        !(rx_i_out_en && rx_q_out_en))
        else $error("two channels on in IF mode");
    a_bypass_inverse: assert property (osc_bypass == !osc_amplifier_on)
        else $error("bypass not inverse of amplifier");
    a_div_onehot: assert property (clk_en |=> $onehot0(rx_lo_div_sel))
        else $error("divider select not one-hot");
    a_gain_steps: assert property (clk_en && rxm_reg[3:0] == 4'h7 ##1 clk_en &&
        $stable(rxm_reg) |=> gain_atten_db == 6'h2A)
        else $error("gain code 7 not 42dB");
    a_read_msb: assert property (clk_en && state_reg == RTC_RDATA && !csn_s2 && sclk_fall &&
        bit_cnt_reg == 3'h0 |=> rdata == $past(mirror_byte[7]))
        else $error("readback MSB wrong");
    a_deselect_idle: assert property (clk_en && csn_s2 |=>
        state_reg == RTC_ADDR && bit_cnt_reg == 3'h0)
        else $error("deselect did not idle engine");
    a_read_no_write: assert property (state_reg == RTC_RDATA |-> !wr_stb_reg)
        else $error("write during read");
    c_write: cover property (wr_stb_reg && addr_reg == rtc_pkg::ADDR_TXC);
    c_read: cover property (state_reg == RTC_RDATA && sclk_fall && bit_cnt_reg == 3'h7);
    c_gen_reset: cover property (gen_rst_reg);
    c_cal_mode: cover property (rxm_reg[4] && rxc_reg[3]);
endmodule // rtc_regs

// ---- tb/rtc_host_model.sv ----
`timescale 1ns/1ps
// Host side of the serial control bus, bit-banged from the system clock
module rtc_host_model (
    // Clock
    input wire logic sys_clk,
    // Serial pins
    output logic sclk,
    output logic csn_n,
    output logic cdata,
    input wire logic rdata
);
    localparam int HALF = 6; // Twice the minimum phase, keeps synchronisers clear
    logic [7:0] rd_byte; // Bits gathered on the rises
    // Idle: deselected, clock parked low
    initial begin
        sclk = 1'b0;
        csn_n = 1'b1;
        cdata = 1'b1;
        rd_byte = 8'h00;
    end
    // Wait edges, then step off the sampling edge
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    // One byte MSB first, data set while clock low, taken on rise
    task automatic shift(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            cdata = b[i];
            tick(HALF);
            sclk = 1'b1;
            rd_byte = {rd_byte[6:0], rdata};
            tick(HALF);
            sclk = 1'b0;
        end
    endtask
    // Address byte then zero or one data byte
    task automatic frame(input logic [7:0] addr, input logic [7:0] data, input bit with_data,
                         output logic [7:0] got);
        logic [7:0] d;
        d = data;
        // Reserved transmit bits always sent as zero
        if (addr == rtc_pkg::ADDR_TXC) begin
            d = d & 8'h53;
        end
        // Forbidden divider code never sent
        if (addr == rtc_pkg::ADDR_RXC && d[2:1] == 2'h3) begin
            d[2] = 1'b0;
        end
        csn_n = 1'b0;
        tick(HALF);
        shift(addr);
        if (with_data) begin
            shift(d);
        end
        got = rd_byte;
        tick(HALF);
        csn_n = 1'b1;
        // Released line no longer shows the last bit
        cdata = ~cdata;
        tick(HALF);
    endtask
endmodule // rtc_host_model

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps
`define CHECK(nm, e, g) \
    begin \
        num_checks++; \
        if ((g) !== (e)) begin \
            errors++; \
            $display("[FAIL] %s expected %h seen %h", nm, e, g); \
        end \
    end
module tb_top;
    // Clock, resets, pins
    logic sys_clk = 1'b0, nrst = 1'b0, reset_pin_n = 1'b1, clk_en = 1'b1;
    logic sclk, csn_n, cdata, rdata;
    logic bias_on, high_if_select, osc_buffer_on, osc_amplifier_on, osc_bypass;
    logic [1:0] osc_negres_setting;
    logic rx_if_mode, rx_i_out_en, rx_q_out_en, rx_i_amp_on, rx_q_amp_on;
    logic mixer1_on, if_chain_on, level_indicator_on, lna_control_pin, bias_voltage_out_on;
    logic [2:0] rx_lo_div_sel;
    logic if_input_select, mixer_output_b_sel, iq_bw_wide;
    logic [5:0] gain_atten_db;
    logic upconverter_on, iq_mod_on, tx_lo_high_band, tx_if_to_pin;
    int errors = 0; // Mismatches
    int num_checks = 0; // Comparisons made
    logic [7:0] got; // Readback value
    logic [2:0] div_exp [3] = '{3'h2, 3'h1, 3'h4}; // One-hot select per code
    always #2 sys_clk = ~sys_clk;
    // Clock enable dropped once to show a frozen block misses a frame
    rtc_regs i_rtc_regs (.sys_clk, .nrst, .clk_en, .sclk, .csn_n, .cdata, .reset_pin_n,
        .rdata, .bias_on, .high_if_select, .osc_buffer_on, .osc_amplifier_on, .osc_bypass,
        .osc_negres_setting, .rx_if_mode, .rx_i_out_en, .rx_q_out_en, .rx_i_amp_on,
        .rx_q_amp_on, .mixer1_on, .if_chain_on, .level_indicator_on, .lna_control_pin,
        .rx_lo_div_sel, .bias_voltage_out_on, .if_input_select, .mixer_output_b_sel,
        .iq_bw_wide, .gain_atten_db, .upconverter_on, .iq_mod_on, .tx_lo_high_band,
        .tx_if_to_pin);
    rtc_host_model i_rtc_host_model (.sys_clk, .sclk, .csn_n, .cdata, .rdata);
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        i_rtc_host_model.frame(a, d, 1'b1, got);
    endtask
    task automatic rd(input logic [7:0] a);
        i_rtc_host_model.frame(a, 8'h00, 1'b1, got);
    endtask
    // All four mirrors read zero, idle outputs
    task automatic t_cleared;
        for (int i = 1; i <= 4; i++) begin
            rd(8'hE0 + 8'(i));
            `CHECK("mirror", 8'h00, got)
        end
        `CHECK("bias", 1'b0, bias_on)
        `CHECK("bypass", 1'b1, osc_bypass)
        `CHECK("div", 3'h2, rx_lo_div_sel)
    endtask
    // Power bits, amplifier bypass, negative resistance code, readback MSB first
    task automatic t_general;
        wr(rtc_pkg::ADDR_GCR, 8'h83);
        `CHECK("bias", 1'b1, bias_on)
        `CHECK("buf", 1'b1, osc_buffer_on)
        `CHECK("amp", 1'b1, osc_amplifier_on)
        `CHECK("bypass", 1'b0, osc_bypass)
        rd(rtc_pkg::ADDR_GCR_RB);
        `CHECK("gcr mirror", 8'h83, got)
        // High IF plan above 75MHz
        for (int c = 0; c < 4; c++) begin
            wr(rtc_pkg::ADDR_GCR, 8'h42 | 8'(c << 2));
            `CHECK("negres", 2'(c), osc_negres_setting)
            `CHECK("highif", 1'b1, high_if_select)
            `CHECK("bypass", 1'b1, osc_bypass)
        end
    endtask
    // Output mode against channel select
    task automatic t_channels;
        logic m, s;
        wr(rtc_pkg::ADDR_RXC, 8'h60);
        `CHECK("ifchain on", 1'b1, if_chain_on)
        for (int c = 0; c < 4; c++) begin
            m = c[0];
            s = c[1];
            wr(rtc_pkg::ADDR_GCR, {2'h2, s, m, 4'h0});
            `CHECK("ifmode", m, rx_if_mode)
            `CHECK("i out", !m | !s, rx_i_out_en)
            `CHECK("q out", !m | s, rx_q_out_en)
            `CHECK("i amp", !m | !s, rx_i_amp_on)
            `CHECK("q amp", !m | s, rx_q_amp_on)
        end
    endtask
    // Receive power bits, LNA_CONTROL_ON pin, divider codes, calibration gate
    task automatic t_rx_ctrl;
        for (int c = 0; c < 3; c++) begin
            wr(rtc_pkg::ADDR_RXC, 8'hB9 | 8'(c << 1));
            `CHECK("mix1", 1'b1, mixer1_on)
            `CHECK("ifchain", 1'b0, if_chain_on)
            `CHECK("level", 1'b1, level_indicator_on)
            `CHECK("bias_voltage_out_on", 1'b1, bias_voltage_out_on)
            `CHECK("lna", 1'b1, lna_control_pin)
            `CHECK("div", div_exp[c], rx_lo_div_sel)
        end
        rd(rtc_pkg::ADDR_RXC_RB);
        `CHECK("rxc mirror", 8'hBD, got)
        wr(rtc_pkg::ADDR_RXM, 8'h10);
        `CHECK("cal mix1", 1'b0, mixer1_on)
        `CHECK("cal lna", 1'b0, lna_control_pin)
        // Mirror and address rights are fixed: writes to a read address do nothing
        wr(rtc_pkg::ADDR_RXC_RB, 8'h00);
        wr(8'h30, 8'h00);
        // Leaving calibration must show the untouched receive control again
        wr(rtc_pkg::ADDR_RXM, 8'h00);
        `CHECK("lna kept", 1'b1, lna_control_pin)
        `CHECK("mix1 back", 1'b1, mixer1_on)
        rd(rtc_pkg::ADDR_RXC_RB);
        `CHECK("rxc kept", 8'hBD, got)
    endtask
    // Routing, bandwidth and every legal gain code, 0 to 8
    task automatic t_rx_mode;
        for (int c = 0; c <= 8; c++) begin
            wr(rtc_pkg::ADDR_RXM, 8'hA0 | 8'(c));
            `CHECK("gain", 6'(c * 6), gain_atten_db)
        end
        `CHECK("if_input_select", 1'b1, if_input_select)
        `CHECK("mixb", 1'b0, mixer_output_b_sel)
        `CHECK("bw", 1'b1, iq_bw_wide)
        wr(rtc_pkg::ADDR_RXM, 8'h40);
        `CHECK("if_input_select", 1'b0, if_input_select)
        `CHECK("mixb", 1'b1, mixer_output_b_sel)
        `CHECK("bw", 1'b0, iq_bw_wide)
        rd(rtc_pkg::ADDR_RXM_RB);
        `CHECK("rxm mirror", 8'h40, got)
    endtask
    // Transmit power and output path; low band below 600MHz first
    task automatic t_tx;
        wr(rtc_pkg::ADDR_TXC, 8'h51);
        `CHECK("upconv", 1'b1, upconverter_on)
        `CHECK("iqmod", 1'b1, iq_mod_on)
        `CHECK("topin", 1'b1, tx_if_to_pin)
        wr(rtc_pkg::ADDR_TXC, 8'h12);
        `CHECK("upconv", 1'b0, upconverter_on)
        `CHECK("topin", 1'b0, tx_if_to_pin)
        `CHECK("lohigh", 1'b1, tx_lo_high_band)
        rd(rtc_pkg::ADDR_TXC_RB);
        `CHECK("txc mirror", 8'h12, got)
    endtask
    // Command, pin and mid-run reset all clear
    task automatic t_clears;
        i_rtc_host_model.frame(rtc_pkg::ADDR_GEN_RESET, 8'h00, 1'b0, got);
        t_cleared();
        wr(rtc_pkg::ADDR_GCR, 8'h80);
        `CHECK("bias before pin", 1'b1, bias_on)
        reset_pin_n = 1'b0;
        i_rtc_host_model.tick(6);
        reset_pin_n = 1'b1;
        i_rtc_host_model.tick(6);
        `CHECK("pin clear", 1'b0, bias_on)
        wr(rtc_pkg::ADDR_GCR, 8'h80);
        `CHECK("bias before nrst", 1'b1, bias_on)
        nrst = 1'b0;
        i_rtc_host_model.tick(3);
        `CHECK("nrst clear", 1'b0, bias_on)
        nrst = 1'b1;
        i_rtc_host_model.tick(3);
        t_cleared();
        // Frame sent while frozen is never seen, then capture resumes
        clk_en = 1'b0;
        wr(rtc_pkg::ADDR_GCR, 8'h80);
        clk_en = 1'b1;
        i_rtc_host_model.tick(3);
        `CHECK("frozen", 1'b0, bias_on)
        wr(rtc_pkg::ADDR_GCR, 8'h80);
        `CHECK("thawed", 1'b1, bias_on)
    endtask
    task automatic give_verdict;
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // Hang guard
    initial begin
        repeat (90000) @(posedge sys_clk);
        errors++;
        give_verdict();
    end
    // Main sequence
    initial begin
        i_rtc_host_model.tick(3);
        nrst = 1'b1;
        i_rtc_host_model.tick(3);
        t_cleared();
        t_general();
        t_channels();
        t_rx_ctrl();
        t_rx_mode();
        t_tx();
        t_clears();
        give_verdict();
    end
endmodule // tb_top
